// File: reset_scope_defs.svh
// constants for reset scope distribution and clock source control
`ifndef RESET_SCOPE_DEFS_SVH
`define RESET_SCOPE_DEFS_SVH

// ---------------------------------------------------------------
// reset cause bit positions
// ---------------------------------------------------------------
`define NUM_CAUSES 8
`define RC_POR 0
`define RC_EXT 1
`define RC_WDT 2
`define RC_BOD 3
`define RC_SUPPLY_MONITOR_3V3 4
`define RC_CPU 5
`define RC_DBG 6
`define RC_JTAG 7

// ---------------------------------------------------------------
// cause masks, one bit per cause, set where the cause clears the group
// ---------------------------------------------------------------
`define MASK_ALL 8'hff
`define MASK_POR_ONLY 8'h01
`define MASK_NO_WDT 8'hfb
`define MASK_NO_BOD 8'hf7
`define MASK_NO_WDT_DBG 8'hbb

// ---------------------------------------------------------------
// register group indices, msb first as in the packed struct
// ---------------------------------------------------------------
`define NUM_GROUPS 11
`define GRP_CPU 10
`define GRP_SLOW_CRYSTAL_OSC 9
`define GRP_RC_CAL 8
`define GRP_OSC_CTRL 7
`define GRP_ATIMER 6
`define GRP_WDT 5
`define GRP_CORE_REGULATOR_CAL 4
`define GRP_SUPPLY_MONITOR_3V3 3
`define GRP_BOD 2
`define GRP_CLK_CTRL 1
`define GRP_DEBUG 0

// ---------------------------------------------------------------
// oscillators and pins
// ---------------------------------------------------------------
`define NUM_OSC 4
`define NUM_OSC_PINS 4
`define PIN_MAIN_IN 0
`define PIN_MAIN_OUT 1
`define PIN_SLOW_IN 2
`define PIN_SLOW_OUT 3
`define OSC_MAIN 0
`define NUM_EVENTS 4

`endif

// File: reset_scope_pkg.sv
// types shared by the reset scope and clock source control block
package reset_scope_pkg;

    // one reset line per register group
    typedef struct packed {
        logic cpu_bus;
        logic slow_osc;
        logic rc_cal;
        logic osc_ctrl;
        logic async_timer;
        logic wdt_ctrl;
        logic core_regulator_cal;
        logic supply_monitor_3v3_ctrl;
        logic bod_ctrl;
        logic clk_ctrl;
        logic debug;
    } grp_rst_t;

    // what a sleep mode switches off
    typedef struct packed {
        logic osc_off;
        logic bod_off;
        logic reg_lp;
    } sleep_cfg_t;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b100
    } sleep_state_t;

endpackage

// File: cause_sync.sv
// two-flop synchroniser for asynchronous reset cause and clock pins
`timescale 1ns/100ps
`default_nettype none
module cause_sync #(
    parameter int WIDTH = 9
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] raw,
    output var logic [WIDTH-1:0] sync_q
);
    logic [WIDTH-1:0] meta_q;

    // ---------------------------------------------------------------
    // first stage feeds only the second stage
    // ---------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= raw;
            sync_q <= meta_q;
        end
    end
endmodule // cause_sync
`default_nettype wire

// File: osc_pin_ctrl.sv
// per-pin takeover of oscillator pins from the gpio controller
`timescale 1ns/100ps
`default_nettype none
`include "reset_scope_defs.svh"
module osc_pin_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] osc_active,
    input wire logic [3:0] osc_drive,
    input wire logic [3:0] osc_oe,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe,
    output var logic [3:0] pin_out,
    output var logic [3:0] pin_oe
);
    // ---------------------------------------------------------------
    // an active oscillator owns its pin whatever gpio asks for
    // ---------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < `NUM_OSC_PINS; p++) begin : g_pin
            wire sel_out = osc_active[p] ? osc_drive[p] : gpio_out[p];
            wire sel_oe = osc_active[p] ? osc_oe[p] : gpio_oe[p];
            always_ff @(posedge clk) begin
                if (reset) begin
                    pin_out[p] <= 1'b0;
                    pin_oe[p] <= 1'b0;
                end else begin
                    pin_out[p] <= sel_out;
                    pin_oe[p] <= sel_oe;
                end
            end
        end
    endgenerate
endmodule // osc_pin_ctrl
`default_nettype wire

// File: reset_scope_and_clock_source_control.sv
// reset scope distribution, sleep gating of clock sources, startup pin
//
// Summary of operation
// - eight reset causes, each clearing own groups
// - slow osc, calibrations cleared only by power-on
// - async timer cleared only by power-on
// - osc, supply monitor, clock control: every cause
// - watchdog skips watchdog; debug skips watchdog, debug
// - brownout control kept through brownout reset
// - sleep stops brownout and fast oscillators; wake restores
// - sleep puts regulator low power; wake restores
// - startup pin shows rc clock until reassigned
// - active oscillator owns its pins over gpio
// - one interrupt line to interrupt controller
// - bus side runs on the bus clock
// - debug halting does not alter behaviour
`timescale 1ns/100ps
`default_nettype none
`include "reset_scope_defs.svh"
module reset_scope_and_clock_source_control
    import reset_scope_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] cause_raw,
    input wire logic rc32k_clk,
    input wire logic gpio_reassign,
    input wire logic sleep_enter,
    input wire sleep_cfg_t sleep_cfg,
    input wire logic wake,
    input wire logic [3:0] osc_sw_en,
    input wire logic slow_osc_sw_en,
    input wire logic bod_sw_en,
    input wire logic [3:0] osc_pad_drive,
    input wire logic [3:0] osc_pad_oe,
    input wire logic [3:0] gpio_out,
    input wire logic [3:0] gpio_oe,
    input wire logic [3:0] scu_event,
    output var grp_rst_t group_rst,
    output var logic [3:0] osc_run,
    output var logic slow_osc_run,
    output var logic brownout_detector_en,
    output var logic core_regulator_lp,
    output var logic rc_startup_clock_pin,
    output var logic rc_startup_clock_pin_oe,
    output var logic [3:0] osc_pin_out,
    output var logic [3:0] osc_pin_oe,
    output var logic scu_irq,
    output var logic [2:0] sleep_state
);
    // ---------------------------------------------------------------
    // synchronised pins
    // ---------------------------------------------------------------
    logic [`NUM_CAUSES:0] sync_q;
    logic [`NUM_CAUSES-1:0] cause_q;
    logic rc32k_q;

    // whole block sits on the bus clock, no second domain
    cause_sync #(.WIDTH(`NUM_CAUSES + 1)) u_sync (
        .clk(clk),
        .reset(reset),
        .raw({rc32k_clk, cause_raw}),
        .sync_q(sync_q)
    );
    assign cause_q = sync_q[`NUM_CAUSES-1:0];
    assign rc32k_q = sync_q[`NUM_CAUSES];

    // ---------------------------------------------------------------
    // reset scope table
    // ---------------------------------------------------------------
    logic [7:0] mask_w [`NUM_GROUPS];
    logic [`NUM_GROUPS-1:0] hit_w;
    logic [`NUM_GROUPS-1:0] grp_q;
    wire any_cause = |cause_q;

    // one mask per group; a zero bit means the cause leaves it alone
    assign mask_w[`GRP_CPU] = `MASK_ALL;
    assign mask_w[`GRP_SLOW_CRYSTAL_OSC] = `MASK_POR_ONLY;
    assign mask_w[`GRP_RC_CAL] = `MASK_POR_ONLY;
    assign mask_w[`GRP_OSC_CTRL] = `MASK_ALL;
    assign mask_w[`GRP_ATIMER] = `MASK_POR_ONLY;
    assign mask_w[`GRP_WDT] = `MASK_NO_WDT;
    assign mask_w[`GRP_CORE_REGULATOR_CAL] = `MASK_POR_ONLY;
    assign mask_w[`GRP_SUPPLY_MONITOR_3V3] = `MASK_ALL;
    assign mask_w[`GRP_BOD] = `MASK_NO_BOD;
    assign mask_w[`GRP_CLK_CTRL] = `MASK_ALL;
    assign mask_w[`GRP_DEBUG] = `MASK_NO_WDT_DBG;

    // each group resets while any of its causes is present
    genvar g;
    generate
        for (g = 0; g < `NUM_GROUPS; g++) begin : g_grp
            assign hit_w[g] = |(cause_q & mask_w[g]);
            always_ff @(posedge clk) begin
                if (reset) begin
                    grp_q[g] <= 1'b1;
                end else begin
                    grp_q[g] <= hit_w[g];
                end
            end
        end
    endgenerate
    assign group_rst = grp_rst_t'(grp_q);

    // ---------------------------------------------------------------
    // sleep state machine
    // ---------------------------------------------------------------
    sleep_state_t state_q, state_d;
    sleep_cfg_t cfg_q, cfg_d;

    // debug halt has no input here, so it cannot steer sleep
    always_comb begin
        state_d = state_q;
        cfg_d = cfg_q;
        case (state_q)
            ST_RUN: begin
                if (sleep_enter) begin
                    state_d = ST_SLEEP;
                    cfg_d = sleep_cfg;
                end
            end
            ST_SLEEP: begin
                if (wake) begin
                    state_d = ST_WAKE;
                end
            end
            ST_WAKE: begin
                state_d = ST_RUN;
                cfg_d = '0;
            end
            default: begin
                state_d = ST_RUN;
                cfg_d = '0;
            end
        endcase
        // a reset cause always lands the machine awake
        if (any_cause) begin
            state_d = ST_RUN;
            cfg_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_RUN;
            cfg_q <= '0;
        end else begin
            state_q <= state_d;
            cfg_q <= cfg_d;
        end
    end
    assign sleep_state = state_q;

    // ---------------------------------------------------------------
    // clock source and regulator gating
    // ---------------------------------------------------------------
    wire asleep_d = (state_d == ST_SLEEP);
    wire osc_gate_d = asleep_d & cfg_d.osc_off;
    wire bod_gate_d = asleep_d & cfg_d.bod_off;
    wire lp_d = asleep_d & cfg_d.reg_lp;

    // software enables come back untouched on wake, no relaunch needed
    always_ff @(posedge clk) begin
        if (reset) begin
            osc_run <= '0;
            slow_osc_run <= 1'b0;
            brownout_detector_en <= 1'b0;
            core_regulator_lp <= 1'b0;
        end else begin
            osc_run <= osc_gate_d ? '0 : osc_sw_en;
            slow_osc_run <= slow_osc_sw_en;
            brownout_detector_en <= bod_sw_en & ~bod_gate_d;
            core_regulator_lp <= lp_d;
        end
    end

    // ---------------------------------------------------------------
    // startup clock pin
    // ---------------------------------------------------------------
    logic rc_pin_own_q;

    // ownership is regained only by a reset, not by gpio toggling back
    always_ff @(posedge clk) begin
        if (reset || any_cause) begin
            rc_pin_own_q <= 1'b1;
        end else if (gpio_reassign) begin
            rc_pin_own_q <= 1'b0;
        end
    end

    // resampled copy; good enough for a slow observation clock
    always_ff @(posedge clk) begin
        if (reset) begin
            rc_startup_clock_pin <= 1'b0;
        end else begin
            rc_startup_clock_pin <= rc32k_q & rc_pin_own_q;
        end
    end
    assign rc_startup_clock_pin_oe = rc_pin_own_q;

    // ---------------------------------------------------------------
    // oscillator pin takeover
    // ---------------------------------------------------------------
    wire [3:0] pin_active = {slow_osc_run, slow_osc_run,
                             osc_run[`OSC_MAIN], osc_run[`OSC_MAIN]};

    osc_pin_ctrl u_pins (
        .clk(clk),
        .reset(reset),
        .osc_active(pin_active),
        .osc_drive(osc_pad_drive),
        .osc_oe(osc_pad_oe),
        .gpio_out(gpio_out),
        .gpio_oe(gpio_oe),
        .pin_out(osc_pin_out),
        .pin_oe(osc_pin_oe)
    );

    // ---------------------------------------------------------------
    // single interrupt line
    // ---------------------------------------------------------------
    // events are merged; the controller must be set up before use
    always_ff @(posedge clk) begin
        if (reset) begin
            scu_irq <= 1'b0;
        end else begin
            scu_irq <= |scu_event;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    chk_cpu_any_cause: assert property (
        any_cause |=> group_rst.cpu_bus
    ) else $error("cpu group missed a reset cause");

    chk_slow_osc_por: assert property (
        !cause_q[`RC_POR] |=> !group_rst.slow_osc && !group_rst.core_regulator_cal
    ) else $error("slow osc or core_regulator cal reset without power-on");

    chk_timer_por_only: assert property (
        cause_q[`RC_POR] |=> group_rst.async_timer && group_rst.rc_cal
    ) else $error("power-on did not clear timer or rc cal");

    chk_clock_ctrl_all: assert property (
        cause_q[`RC_JTAG] |=> group_rst.clk_ctrl && group_rst.supply_monitor_3v3_ctrl
            && group_rst.osc_ctrl
    ) else $error("clock control groups missed jtag reset");

    chk_wdt_keeps: assert property (
        (cause_q == 8'h04) |=> !group_rst.wdt_ctrl && !group_rst.debug
    ) else $error("watchdog reset cleared watchdog or debug");

    chk_debug_keeps: assert property (
        (cause_q == 8'h40) |=> !group_rst.debug && group_rst.wdt_ctrl
    ) else $error("debug reset scope wrong");

    chk_bod_keeps: assert property (
        (cause_q == 8'h08) |=> !group_rst.bod_ctrl && group_rst.cpu_bus
    ) else $error("brownout reset cleared brownout control");

    chk_scope_ext: assert property (
        (cause_q == 8'h02) |=> (grp_q == 11'h4af)
    ) else $error("external reset scope mismatch");

    chk_sleep_gates: assert property (
        (state_q == ST_SLEEP && cfg_q.osc_off) |-> (osc_run == 4'h0)
    ) else $error("oscillator running in gated sleep");

    chk_wake_restore: assert property (
        (state_q == ST_WAKE) ##1 (state_q == ST_RUN)[*2] |->
            (osc_run == $past(osc_sw_en)) && !core_regulator_lp
    ) else $error("sources not restored after wake");

    chk_reg_lp: assert property (
        (state_q == ST_SLEEP && cfg_q.reg_lp) |-> core_regulator_lp
    ) else $error("regulator not low power in sleep");

    chk_rc_pin_drop: assert property (
        gpio_reassign && !any_cause |=> !rc_startup_clock_pin_oe
            ##1 !rc_startup_clock_pin
    ) else $error("startup pin kept after reassign");

    // pin copy lags the raw rc level by sync, sync and output register
    chk_rc_pin_copy: assert property (
        !$past(reset) && !$past(reset, 2) && !$past(reset, 3) && $past(rc_pin_own_q)
            |-> rc_startup_clock_pin == $past(rc32k_clk, 3)
    ) else $error("startup pin does not follow rc clock");

    chk_pin_takeover: assert property (
        slow_osc_run && !$past(reset) |=> osc_pin_oe[`PIN_SLOW_IN]
            == $past(osc_pad_oe[`PIN_SLOW_IN])
    ) else $error("slow osc pin not owned");

    chk_irq_event: assert property (
        (scu_event != 4'h0) |=> scu_irq
    ) else $error("event did not raise interrupt");

    cov_sleep_wake: cover property (
        (state_q == ST_SLEEP) ##[1:20] (state_q == ST_WAKE)
    );
    cov_bod_reset: cover property (cause_q == 8'h08);
    cov_pin_reassign: cover property (rc_pin_own_q ##1 !rc_pin_own_q);
    cov_cause_in_sleep: cover property ((state_q == ST_SLEEP) && any_cause);

endmodule // reset_scope_and_clock_source_control
`default_nettype wire

// File: cause_source_model.sv
// far-side model: reset cause sources and the free-running rc clock
`timescale 1ns/100ps
`default_nettype none
module cause_source_model #(
    parameter real RC_HALF = 15625.0
) (
    output var logic [7:0] cause_raw,
    output var logic rc32k_clk
);
    // ------------------------------------------------------------
    // cause levels, held by each source until it withdraws
    // ------------------------------------------------------------
    initial begin
        cause_raw = 8'h00;
        rc32k_clk = 1'b0;
    end

    // rc clock runs free, unrelated in phase to the bus clock
    always #(RC_HALF) rc32k_clk = ~rc32k_clk;

    // one bit per source; several may be present together
    task automatic hold_cause(input logic [7:0] v);
        cause_raw = v;
    endtask
endmodule // cause_source_model
`default_nettype wire

// File: testbench.sv
// self-checking bench for reset scope and clock source control
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import reset_scope_pkg::*;
    typedef struct {int kind; int due; logic [31:0] exp;} note_t;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic gpio_reassign = 1'b0;
    logic sleep_enter = 1'b0;
    sleep_cfg_t sleep_cfg = '0;
    logic wake = 1'b0;
    logic [3:0] osc_sw_en = 4'h0;
    logic slow_osc_sw_en = 1'b0;
    logic bod_sw_en = 1'b1;
    logic [3:0] osc_pad_drive = 4'h0;
    logic [3:0] osc_pad_oe = 4'h0;
    logic [3:0] gpio_out = 4'h0;
    logic [3:0] gpio_oe = 4'h0;
    logic [3:0] scu_event = 4'h0;
    wire logic [7:0] cause_raw;
    wire logic rc32k_clk;
    grp_rst_t group_rst;
    logic [3:0] osc_run;
    logic slow_osc_run, brownout_detector_en, core_regulator_lp, scu_irq;
    logic rc_startup_clock_pin, rc_startup_clock_pin_oe;
    logic [3:0] osc_pin_out, osc_pin_oe;
    logic [2:0] sleep_state;
    int cyc = 0;
    int n_errors = 0;
    int total_checks = 0;
    logic [31:0] seed = 32'hf70d425a;
    note_t notes[$];

    always #12.5 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // rc clock sped up so the startup pin copy toggles within a short run
    cause_source_model #(.RC_HALF(131.0)) src (.cause_raw(cause_raw), .rc32k_clk(rc32k_clk));

    reset_scope_and_clock_source_control uut (
        .clk(clk), .reset(reset), .cause_raw(cause_raw), .rc32k_clk(rc32k_clk),
        .gpio_reassign(gpio_reassign), .sleep_enter(sleep_enter), .sleep_cfg(sleep_cfg),
        .wake(wake), .osc_sw_en(osc_sw_en), .slow_osc_sw_en(slow_osc_sw_en),
        .bod_sw_en(bod_sw_en), .osc_pad_drive(osc_pad_drive), .osc_pad_oe(osc_pad_oe),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .scu_event(scu_event),
        .group_rst(group_rst), .osc_run(osc_run), .slow_osc_run(slow_osc_run),
        .brownout_detector_en(brownout_detector_en), .core_regulator_lp(core_regulator_lp),
        .rc_startup_clock_pin(rc_startup_clock_pin),
        .rc_startup_clock_pin_oe(rc_startup_clock_pin_oe), .osc_pin_out(osc_pin_out),
        .osc_pin_oe(osc_pin_oe), .scu_irq(scu_irq), .sleep_state(sleep_state));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // groups held for a set of causes, msb first as in the struct
    function automatic logic [10:0] grp_of(input logic [7:0] v);
        return {|v, v[0], v[0], |v, v[0], |(v & 8'hfb), v[0], |v, |(v & 8'hf7), |v,
                |(v & 8'hbb)};
    endfunction

    // one compare per kind of result
    task automatic cmp_scope(input logic [31:0] e);
        compare(e, 32'(group_rst));
    endtask

    task automatic cmp_sleep(input logic [31:0] e);
        compare(e, 32'({sleep_state, slow_osc_run, brownout_detector_en,
                        core_regulator_lp, osc_run}));
    endtask

    // pin data is only meaningful once the pin is handed back
    task automatic cmp_start_pin(input logic [31:0] e);
        compare(e, 32'({rc_startup_clock_pin_oe,
                        rc_startup_clock_pin & ~rc_startup_clock_pin_oe}));
    endtask

    task automatic cmp_pads(input logic [31:0] e);
        compare(e, 32'({osc_pin_out, osc_pin_oe}));
    endtask

    task automatic cmp_irq(input logic [31:0] e);
        compare(e, 32'(scu_irq));
    endtask

    task automatic note(input int k, input int d, input logic [31:0] e);
        notes.push_back('{k, cyc + d, e});
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    task automatic compare(input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // watcher: outputs sampled mid-cycle, oldest note first
    always @(negedge clk) begin
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            case (notes[0].kind)
                0: cmp_scope(notes[0].exp);
                1: cmp_sleep(notes[0].exp);
                2: cmp_start_pin(notes[0].exp);
                3: cmp_pads(notes[0].exp);
                default: cmp_irq(notes[0].exp);
            endcase
            void'(notes.pop_front());
        end
    end

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic [7:0] v;
        logic [3:0] own;
        step(5);
        note(0, 0, 32'h7ff);
        note(2, 0, 32'h2);
        reset = 1'b0;
        note(0, 1, 32'h0);
        step(2);
        // every single cause, then a random mix of causes
        for (int i = 0; i < 9; i++) begin
            r = rnd();
            v = (i < 8) ? 8'h01 << i : r[7:0];
            src.hold_cause(v);
            note(0, 4, 32'(grp_of(v)));
            step(6);
            src.hold_cause(8'h00);
            note(0, 4, 32'h0);
            step(6);
        end
        // reassign is ignored while a cause is present
        src.hold_cause(8'h02);
        step(3);
        gpio_reassign = 1'b1;
        note(2, 2, 32'h2);
        step(1);
        gpio_reassign = 1'b0;
        src.hold_cause(8'h00);
        step(5);
        gpio_reassign = 1'b1;
        note(2, 2, 32'h0);
        step(1);
        gpio_reassign = 1'b0;
        step(3);
        // random pin ownership and events
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            {slow_osc_sw_en, osc_sw_en} = r[4:0];
            {osc_pad_drive, osc_pad_oe, gpio_out, gpio_oe} = r[20:5];
            scu_event = r[24:21] & {4{r[25]}};
            bod_sw_en = r[26];
            note(1, 3, 32'({ST_RUN, slow_osc_sw_en, bod_sw_en, 1'b0, osc_sw_en}));
            own = {slow_osc_sw_en, slow_osc_sw_en, osc_sw_en[0], osc_sw_en[0]};
            note(3, 3, 32'({(own & osc_pad_drive) | (~own & gpio_out),
                            (own & osc_pad_oe) | (~own & gpio_oe)}));
            note(4, 3, 32'(|scu_event));
            step(4);
        end
        // every sleep mode, then wake restores everything
        slow_osc_sw_en = 1'b1;
        bod_sw_en = 1'b1;
        for (int m = 0; m < 8; m++) begin
            sleep_cfg = sleep_cfg_t'(m[2:0]);
            sleep_enter = 1'b1;
            note(1, 1, 32'({ST_SLEEP, 1'b1, ~sleep_cfg.bod_off, sleep_cfg.reg_lp,
                            sleep_cfg.osc_off ? 4'h0 : osc_sw_en}));
            step(1);
            sleep_enter = 1'b0;
            step(3);
            wake = 1'b1;
            note(1, 1, 32'({ST_WAKE, 3'b110, osc_sw_en}));
            note(1, 2, 32'({ST_RUN, 3'b110, osc_sw_en}));
            step(1);
            wake = 1'b0;
            step(2);
        end
        // a wake outside sleep changes nothing
        wake = 1'b1;
        note(1, 1, 32'({ST_RUN, 3'b110, osc_sw_en}));
        step(1);
        wake = 1'b0;
        step(4);
        results();
    end

    // watchdog: the sequence needs well under 400 cycles
    initial begin
        #(25.0 * 2000);
        n_errors++;
        results();
    end
endmodule // testbench
`default_nettype wire
